/* rtl/dsp_op_pkg.sv */
package dsp_op_pkg;
  // datapath widths
  localparam int DATA_W  = 32;
  localparam int HALF_W  = 16;
  localparam int SHAMT_W = 7;
  localparam int NREG    = 8;
  localparam int IDX_W   = 3;
  ////////////////////////////////////////////////////////////////////////////
  // instruction layout
  localparam int          PREFIX_LSB = 26;
  localparam logic [5:0]  OP_PREFIX  = 6'h3E;
  localparam int          BFIELD_W   = 16;
  localparam int          AFIELD_LSB = 16;
  localparam int          DBL_LSB    = 12;   // 4-bit double opcode
  localparam int          OPC_LSB    = 8;    // 8-bit single opcode
  localparam int          SX_LSB     = 6;
  localparam int          SY_LSB     = 4;
  localparam int          DZ_LSB     = 0;
  localparam int          SE_LSB     = 10;
  localparam int          SF_LSB     = 8;
  localparam int          DG_LSB     = 2;
  localparam int          DU_LSB     = 0;
  localparam int          SHAMT_LSB  = 16;   // shift count in the upper word of y
  ////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [3:0]  DBL_MUL    = 4'h4;
  localparam logic [3:0]  DBL_ADD    = 4'h7;
  localparam logic [3:0]  DBL_SUB    = 4'h6;
  localparam logic [5:0]  OPC_ADD    = 6'h2C;  // upper six bits of single opcode
  localparam logic [5:0]  OPC_SUB    = 6'h28;
  localparam logic [5:0]  OPC_SHA    = 6'h24;
  localparam logic [1:0]  COND_ALW   = 2'h1;
  localparam logic [1:0]  COND_SET   = 2'h2;
  localparam logic [1:0]  COND_CLR   = 2'h3;
  ////////////////////////////////////////////////////////////////////////////
  // register indices and alu operations
  typedef enum logic [2:0] {
    REG_A0 = 3'b000, REG_A1 = 3'b001, REG_M0 = 3'b010, REG_M1 = 3'b011,
    REG_X0 = 3'b100, REG_X1 = 3'b101, REG_Y0 = 3'b110, REG_Y1 = 3'b111
  } dsp_reg_e;
  typedef enum logic [1:0] {
    ALU_ADD = 2'b00, ALU_SUB = 2'b01, ALU_SHA = 2'b10
  } alu_op_e;
  // flag update select codes
  localparam logic [2:0]  FSEL_CARRY = 3'h0;
  localparam logic [2:0]  FSEL_NEG   = 3'h1;
  localparam logic [2:0]  FSEL_ZERO  = 3'h2;
  localparam logic [2:0]  FSEL_OVF   = 3'h3;
  localparam logic [2:0]  FSEL_GT    = 3'h4;
  localparam logic [2:0]  FSEL_GE    = 3'h5;
  ////////////////////////////////////////////////////////////////////////////
  // default operand decode tables, entry i at bits [3i +: 3]
  localparam logic [11:0] SX_MAP_DEF = 12'hB08;  // a0 a1 x0 x1
  localparam logic [11:0] SY_MAP_DEF = 12'hF9A;  // m0 m1 y0 y1
  localparam logic [11:0] DU_MAP_DEF = 12'hD08;  // a0 a1 x0 y0
  localparam logic [11:0] SE_MAP_DEF = 12'hD61;  // a1 x0 x1 y0
  localparam logic [11:0] SF_MAP_DEF = 12'hFA1;  // a1 x0 y0 y1
  localparam logic [11:0] DG_MAP_DEF = 12'h688;  // a0 a1 m0 m1
  // alu_dest table: 4 bits per entry, bit 3 marks a valid code
  localparam logic [63:0] DZ_MAP_DEF = 64'h00000000_FEDCBA98;
  localparam int          DZ_VLD     = 3;

  // two-bit operand field to register index
  function automatic logic [2:0] map2(input logic [11:0] tbl, input logic [1:0] sel);
    map2 = tbl[3*sel +: 3];
  endfunction
  // four-bit destination field to {valid, index}
  function automatic logic [3:0] map4(input logic [63:0] tbl, input logic [3:0] sel);
    map4 = tbl[4*sel +: 4];
  endfunction
endpackage

/* rtl/dsp_mul_core.sv */
`timescale 1ns/100ps
// signed multiply of the upper words of both sources
module dsp_mul_core #(
  parameter int DATA_W = dsp_op_pkg::DATA_W,
  parameter int HALF_W = dsp_op_pkg::HALF_W
) (
  // operands
  input  wire logic [DATA_W-1:0] i_src_first,
  input  wire logic [DATA_W-1:0] i_src_second,
  // product
  output logic      [DATA_W-1:0] o_product
);
  logic signed [HALF_W-1:0]   a_hi;  // upper word of first source
  logic signed [HALF_W-1:0]   b_hi;  // upper word of second source
  logic signed [2*HALF_W-1:0] prod;  // full product

  // product is sign-extended or trimmed into the data width
  always_comb begin
    a_hi      = i_src_first[DATA_W-1 -: HALF_W];
    b_hi      = i_src_second[DATA_W-1 -: HALF_W];
    prod      = a_hi * b_hi;
    o_product = DATA_W'(prod);
  end
endmodule // dsp_mul_core

/* rtl/dsp_alu_core.sv */
`timescale 1ns/100ps
// add, subtract and arithmetic shift with result conditions
module dsp_alu_core #(
  parameter int DATA_W  = dsp_op_pkg::DATA_W,
  parameter int SHAMT_W = dsp_op_pkg::SHAMT_W
) (
  // operation and operands
  input  wire dsp_op_pkg::alu_op_e i_op,
  input  wire logic [DATA_W-1:0]   i_x,
  input  wire logic [DATA_W-1:0]   i_y,
  // result and conditions
  output logic      [DATA_W-1:0]   o_result,
  output logic                     o_carry,
  output logic                     o_neg,
  output logic                     o_zero,
  output logic                     o_ovf
);
  logic        [DATA_W:0]    sum;    // one extra bit keeps carry or borrow
  logic signed [SHAMT_W-1:0] shamt;  // signed shift count
  logic        [SHAMT_W-1:0] mag;    // shift distance

  always_comb begin
    sum      = '0;
    shamt    = SHAMT_W'(i_y >> dsp_op_pkg::SHAMT_LSB);
    mag      = '0;
    o_result = '0;
    o_carry  = 1'b0;
    o_ovf    = 1'b0;
    unique case (i_op)
      dsp_op_pkg::ALU_ADD: begin
        sum      = {1'b0, i_x} + {1'b0, i_y};
        o_result = sum[DATA_W-1:0];
        o_carry  = sum[DATA_W];
        o_ovf    = (i_x[DATA_W-1] == i_y[DATA_W-1]) &&
                   (o_result[DATA_W-1] != i_x[DATA_W-1]);
      end
      dsp_op_pkg::ALU_SUB: begin
        sum      = {1'b0, i_x} - {1'b0, i_y};
        o_result = sum[DATA_W-1:0];
        o_carry  = sum[DATA_W];
        o_ovf    = (i_x[DATA_W-1] != i_y[DATA_W-1]) &&
                   (o_result[DATA_W-1] != i_x[DATA_W-1]);
      end
      dsp_op_pkg::ALU_SHA: begin
        // non-negative count shifts left, negative shifts right with sign fill
        if (!shamt[SHAMT_W-1]) begin
          mag      = shamt;
          o_result = i_x << mag;
        end else begin
          mag      = SHAMT_W'(-shamt);
          o_result = DATA_W'($signed(i_x) >>> mag);
        end
      end
      default: o_result = '0;  // unused code
    endcase
    o_neg  = o_result[DATA_W-1];
    o_zero = (o_result == '0);
  end
endmodule // dsp_alu_core

/* rtl/dsp_operation_decoder.sv */
`timescale 1ns/100ps
// How it works
// - one 32-bit word holds both fields
// - upper field transfer, lower field data operation
// - both fields execute independently in parallel
// - double, conditional and unconditional operation classes
// - alu x, y sources and eight-way destination
// - parallel alu and multiply destination sets
// - first and second multiply source sets
// - unconditional alu and shift update the flag
// - conditional and multiply leave flag alone
// - status select picks which condition is stored
// - multiply-only double op in one cycle
// - add with parallel multiply, updates flag
// - subtract with parallel multiply, one cycle
// - unconditional arithmetic shift updates flag
// - shift if flag set, flag kept
module dsp_operation_decoder #(
  // data width, then the operand decode tables
  parameter int          DATA_W = dsp_op_pkg::DATA_W,
  parameter logic [11:0] SX_MAP = dsp_op_pkg::SX_MAP_DEF,
  parameter logic [11:0] SY_MAP = dsp_op_pkg::SY_MAP_DEF,
  parameter logic [11:0] DU_MAP = dsp_op_pkg::DU_MAP_DEF,
  parameter logic [11:0] SE_MAP = dsp_op_pkg::SE_MAP_DEF,
  parameter logic [11:0] SF_MAP = dsp_op_pkg::SF_MAP_DEF,
  parameter logic [11:0] DG_MAP = dsp_op_pkg::DG_MAP_DEF,
  // alu_dest table holds {valid, index}
  parameter logic [63:0] DZ_MAP = dsp_op_pkg::DZ_MAP_DEF
) (
  // clock and reset
  // one clock domain, synchronous reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,

  // instruction from the core pipeline
  // decoded in the cycle it is valid
  input  wire logic                  i_insn_valid,
  input  wire logic [31:0]           i_insn,

  // status word select and transfer-side register load
  // the select is a level, read each cycle
  input  wire logic [2:0]            i_flag_update_select,
  input  wire logic                  i_xfer_we,
  input  wire logic [2:0]            i_xfer_sel,
  input  wire logic [DATA_W-1:0]     i_xfer_data,

  // register read port
  // read data is one edge old
  input  wire logic [2:0]            i_rd_sel,
  output logic      [DATA_W-1:0]     o_rd_data,

  // transfer field handed on, decode status
  // pulses last one cycle, the flag is a level
  output logic                       o_transfer_valid,
  output logic      [15:0]           o_transfer_field,
  output logic                       o_dsp_cond_flag,
  output logic                       o_op_executed,
  output logic                       o_op_illegal
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  // eight registers are few enough for flip-flops,
  // and every operand mux reads them all at once
  // each state register pairs with its next value
  logic [DATA_W-1:0]            regs_q [dsp_op_pkg::NREG];  // dsp register file
  logic [DATA_W-1:0]            regs_d [dsp_op_pkg::NREG];
  logic                         flag_q, flag_d;             // dsp_cond_flag
  logic [DATA_W-1:0]            rd_q, rd_d;                 // read port data
  logic                         xv_q, xv_d;                 // transfer valid
  logic [15:0]                  xf_q, xf_d;                 // transfer field
  logic                         ex_q, ex_d;                 // op executed
  logic                         il_q, il_d;                 // op illegal

  // fields of the operation half
  logic [dsp_op_pkg::BFIELD_W-1:0] bf;                      // operation field
  logic                         is_dsp;                     // prefix matches
  logic                         is_dbl;                     // double op class
  logic [3:0]                   dbl_opc;
  logic [5:0]                   sgl_opc;
  logic [1:0]                   cond;

  // register indices from the tables
  logic [2:0]                   sx_idx, sy_idx, du_idx;
  logic [2:0]                   se_idx, sf_idx, dg_idx;
  logic [3:0]                   dz_ent;                     // {valid, index}

  // execution units and their conditions
  dsp_op_pkg::alu_op_e          alu_op;
  logic [DATA_W-1:0]            alu_res, mul_res;
  logic                         c_carry, c_neg, c_zero, c_ovf;
  logic                         cond_new;                   // selected condition
  // cond_new reaches the flag on unconditional ops and double add/subtract only

  ////////////////////////////////////////////////////////////////////////////
  // field split and operand decode
  // one decode serves the whole word, no state here
  // both halves come from the same word, neither alters the other
  // the prefix alone marks a dsp word; the transfer
  // half only travels on to the transfer unit
  // an unlisted double code still drives both units
  always_comb begin
    is_dsp  = (i_insn[31:dsp_op_pkg::PREFIX_LSB] == dsp_op_pkg::OP_PREFIX);
    bf      = i_insn[dsp_op_pkg::BFIELD_W-1:0];
    dbl_opc = bf[dsp_op_pkg::DBL_LSB +: 4];
    sgl_opc = bf[dsp_op_pkg::OPC_LSB+2 +: 6];
    cond    = bf[dsp_op_pkg::OPC_LSB +: 2];
    is_dbl  = (bf[15:14] == 2'b01);

    // operand positions fixed within the lower halfword
    sx_idx  = dsp_op_pkg::map2(SX_MAP, bf[dsp_op_pkg::SX_LSB +: 2]);
    sy_idx  = dsp_op_pkg::map2(SY_MAP, bf[dsp_op_pkg::SY_LSB +: 2]);
    dz_ent  = dsp_op_pkg::map4(DZ_MAP, bf[dsp_op_pkg::DZ_LSB +: 4]);
    du_idx  = dsp_op_pkg::map2(DU_MAP, bf[dsp_op_pkg::DU_LSB +: 2]);
    dg_idx  = dsp_op_pkg::map2(DG_MAP, bf[dsp_op_pkg::DG_LSB +: 2]);
    se_idx  = dsp_op_pkg::map2(SE_MAP, bf[dsp_op_pkg::SE_LSB +: 2]);
    sf_idx  = dsp_op_pkg::map2(SF_MAP, bf[dsp_op_pkg::SF_LSB +: 2]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // alu operation select: double ops compare the four-bit code with DBL_SUB, singles their opcode
  // the alu runs every cycle and its result is dropped
  // when no write follows: no gating on the operand path
  always_comb begin
    // add is the resting choice
    alu_op = dsp_op_pkg::ALU_ADD;
    if (is_dbl) begin
      alu_op = (dbl_opc == dsp_op_pkg::DBL_SUB) ? dsp_op_pkg::ALU_SUB
                                                : dsp_op_pkg::ALU_ADD;
    end else if (sgl_opc == dsp_op_pkg::OPC_SUB) begin
      // single ops pick by their six-bit opcode
      alu_op = dsp_op_pkg::ALU_SUB;
    end else if (sgl_opc == dsp_op_pkg::OPC_SHA) begin
      alu_op = dsp_op_pkg::ALU_SHA;
    end
  end

  // execution units
  // alu and multiplier share the cycle, so a double op finishes in one state
  // operands index the register file directly, so a
  // result written at one edge feeds the next word
  // alu: add, subtract and arithmetic shift
  dsp_alu_core #(
    .DATA_W  (DATA_W),
    .SHAMT_W (dsp_op_pkg::SHAMT_W)
  ) u_alu (
    .i_op     (alu_op),
    .i_x      (regs_q[sx_idx]),
    .i_y      (regs_q[sy_idx]),
    .o_result (alu_res),
    .o_carry  (c_carry),
    .o_neg    (c_neg),
    .o_zero   (c_zero),
    .o_ovf    (c_ovf)
  );

  // multiplier sources use their own tables
  dsp_mul_core #(
    .DATA_W (DATA_W),
    .HALF_W (dsp_op_pkg::HALF_W)
  ) u_mul (
    .i_src_first  (regs_q[se_idx]),
    .i_src_second (regs_q[sf_idx]),
    .o_product    (mul_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // condition chosen by the status word select
  // gt and ge read sign and overflow together
  // codes 6 and 7 mean nothing, so the flag stays
  always_comb begin
    unique case (i_flag_update_select)
      dsp_op_pkg::FSEL_CARRY: cond_new = c_carry;
      dsp_op_pkg::FSEL_NEG:   cond_new = c_neg;
      dsp_op_pkg::FSEL_ZERO:  cond_new = c_zero;
      dsp_op_pkg::FSEL_OVF:   cond_new = c_ovf;
      dsp_op_pkg::FSEL_GT:    cond_new = !(c_neg ^ c_ovf) && !c_zero;
      dsp_op_pkg::FSEL_GE:    cond_new = !(c_neg ^ c_ovf);
      default:                cond_new = flag_q;  // reserved codes keep the flag
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of register file, flag and status
  // one always_comb here, one always_ff below
  // operation result beats a transfer load to the same register in one cycle
  // order within one cycle:
  //   1. copy the state and clear the pulses
  //   2. apply a strobed transfer load
  //   3. apply the operation, which may overwrite 2
  //   4. take the flag from the selected condition
  // a refused word raises the illegal pulse, not execute; the transfer passes
  // a false condition raises nothing, the transfer passes
  always_comb begin
    regs_d = regs_q;
    flag_d = flag_q;
    ex_d   = 1'b0;
    il_d   = 1'b0;
    xv_d   = i_insn_valid && is_dsp;
    xf_d   = i_insn[dsp_op_pkg::AFIELD_LSB +: 16];
    // read port samples the state before this edge
    rd_d   = regs_q[i_rd_sel];

    // transfer side load runs whatever the operation field does
    if (i_xfer_we) begin
      regs_d[i_xfer_sel] = i_xfer_data;
    end

    // only a valid dsp word reaches the operation decode
    if (i_insn_valid && is_dsp) begin
      if (is_dbl) begin
        unique case (dbl_opc)
          dsp_op_pkg::DBL_MUL: begin
            // multiply alone leaves the flag
            regs_d[dg_idx] = mul_res;
            ex_d           = 1'b1;
          end
          dsp_op_pkg::DBL_ADD, dsp_op_pkg::DBL_SUB: begin
            // same-register clash: multiply written last wins
            // the alu half still updates the flag
            regs_d[du_idx] = alu_res;
            regs_d[dg_idx] = mul_res;
            flag_d         = cond_new;
            ex_d           = 1'b1;
          end
          default: il_d = 1'b1;  // other double codes are not decoded here
        endcase
      end else if ((sgl_opc == dsp_op_pkg::OPC_ADD ||
                    sgl_opc == dsp_op_pkg::OPC_SUB ||
                    sgl_opc == dsp_op_pkg::OPC_SHA) &&
                   cond != 2'b00 && dz_ent[dsp_op_pkg::DZ_VLD]) begin
        unique case (cond)
          dsp_op_pkg::COND_ALW: begin
            // write and flag update together
            regs_d[dz_ent[2:0]] = alu_res;
            flag_d              = cond_new;
            ex_d                = 1'b1;
          end
          dsp_op_pkg::COND_SET: begin
            // false condition acts as no-operation, flag never written
            // so a chain of conditional ops tests one flag
            if (flag_q) begin
              regs_d[dz_ent[2:0]] = alu_res;
              ex_d                = 1'b1;
            end
          end
          dsp_op_pkg::COND_CLR: begin
            // mirror of the flag-set form
            if (!flag_q) begin
              regs_d[dz_ent[2:0]] = alu_res;
              ex_d                = 1'b1;
            end
          end
          default: il_d = 1'b1;
        endcase
      end else begin
        // codes outside this block, such as logical shifts
        il_d = 1'b1;  // unsupported operation field: nothing changes
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  // reset clears registers, flag and every pulse
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      // clear the whole register file
      for (int i = 0; i < dsp_op_pkg::NREG; i++) begin
        regs_q[i] <= '0;
      end
      flag_q <= 1'b0;
      rd_q   <= '0;
      xv_q   <= 1'b0;
      xf_q   <= '0;
      ex_q   <= 1'b0;
      il_q   <= 1'b0;
    end else begin
      // every next value is taken, no enable
      regs_q <= regs_d;
      flag_q <= flag_d;
      rd_q   <= rd_d;
      xv_q   <= xv_d;
      xf_q   <= xf_d;
      ex_q   <= ex_d;
      il_q   <= il_d;
    end
  end

  // outputs straight from flip-flops
  // no pin is combinational, the core sees clean edges
  // data path
  assign o_rd_data        = rd_q;
  assign o_transfer_valid = xv_q;
  assign o_transfer_field = xf_q;
  // status
  assign o_dsp_cond_flag  = flag_q;
  assign o_op_executed    = ex_q;
  assign o_op_illegal     = il_q;
endmodule // dsp_operation_decoder

/* tb/dsp_operation_decoder_properties.sv */
`timescale 1ns/100ps
// port-level checks on the decoder, one clock domain
module dsp_op_checker (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  // instruction side
  input wire logic        i_insn_valid,
  input wire logic [31:0] i_insn,
  input wire logic [2:0]  i_flag_update_select,
  // decode results
  input wire logic        o_transfer_valid,
  input wire logic [15:0] o_transfer_field,
  input wire logic        o_dsp_cond_flag,
  input wire logic        o_op_executed,
  input wire logic        o_op_illegal
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic dsp_w;   // a dsp word is taken at this edge
  logic cond_w;  // single op carrying a flag condition
  logic add_w;   // unconditional add
  assign dsp_w  = i_insn_valid && (i_insn[31:26] == dsp_op_pkg::OP_PREFIX);
  assign cond_w = dsp_w && i_insn[15] && i_insn[9];
  assign add_w  = dsp_w && (i_insn[15:8] == {dsp_op_pkg::OPC_ADD, dsp_op_pkg::COND_ALW});
  //////////////////////////////////////////////////////////////////////////////
  a_xfer_on_prefix: assert property (dsp_w |=> o_transfer_valid)
    else $error("no transfer pulse after a dsp word");
  a_xfer_needs_prefix: assert property (!dsp_w |=> !o_transfer_valid)
    else $error("transfer pulse without a dsp word");
  a_field_copy: assert property (i_insn_valid |=> o_transfer_field == $past(i_insn[31:16]))
    else $error("transfer field not handed on");
  a_exec_from_word: assert property (o_op_executed |-> $past(dsp_w))
    else $error("execute pulse without a dsp word");
  a_illegal_alone: assert property (o_op_illegal |-> !o_op_executed && $past(dsp_w))
    else $error("illegal pulse together with execute");
  a_cond_keeps_flag: assert property (cond_w |=> $stable(o_dsp_cond_flag))
    else $error("conditional op changed the flag");
  a_mul_keeps_flag: assert property (dsp_w && i_insn[15:12] == dsp_op_pkg::DBL_MUL
    |=> $stable(o_dsp_cond_flag))
    else $error("multiply changed the flag");
  a_idle_keeps_flag: assert property (!dsp_w |=> $stable(o_dsp_cond_flag))
    else $error("flag moved without an operation");
  a_set_false_nop: assert property (cond_w && !i_insn[8] && !o_dsp_cond_flag
    |=> !o_op_executed)
    else $error("flag-set op ran with flag clear");
  a_clr_false_nop: assert property (cond_w && i_insn[8] && o_dsp_cond_flag
    |=> !o_op_executed)
    else $error("flag-clear op ran with flag set");
  a_always_add_runs: assert property (add_w && !i_insn[3] |=> o_op_executed)
    else $error("unconditional add did not run");
  a_select_keep: assert property (add_w && i_flag_update_select[2:1] == 2'b11
    |=> $stable(o_dsp_cond_flag))
    else $error("keep select still changed the flag");
endmodule // dsp_op_checker

bind dsp_operation_decoder dsp_op_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_insn_valid(i_insn_valid), .i_insn(i_insn),
  .i_flag_update_select(i_flag_update_select), .o_transfer_valid(o_transfer_valid),
  .o_transfer_field(o_transfer_field), .o_dsp_cond_flag(o_dsp_cond_flag),
  .o_op_executed(o_op_executed), .o_op_illegal(o_op_illegal));

/* tb/core_issue_model.sv */
`timescale 1ns/100ps
// core pipeline issue stage: hands one whole 32-bit word per cycle
module core_issue_model (
  // clock and issue request
  input  wire logic        i_ref_clk,
  input  wire logic        i_issue,
  input  wire logic [31:0] i_word,
  // instruction bus to the decoder
  output logic             o_insn_valid,
  output logic [31:0]      o_insn
);
  logic [31:0] last_q = 32'h00000000;  // last word issued
  // remember what was sent so the idle bus can show its inverse
  always_ff @(posedge i_ref_clk) begin
    if (i_issue) begin
      last_q <= i_word;
    end
  end
  // idle bus never repeats the last word, so stale decode shows up
  always_comb begin
    o_insn_valid = i_issue;
    o_insn       = i_issue ? i_word : ~last_q;
  end
endmodule // core_issue_model

/* tb/dsp_operation_decoder_bench.sv */
`timescale 1ns/100ps
module dsp_operation_decoder_bench;
  // one decode case and its expected outcome
  typedef struct packed {
    logic dsp; logic [15:0] lo; logic [2:0] sel; logic [2:0] d; logic [31:0] v;
    logic fl; logic ex; logic il;
  } case_s;
  logic        i_ref_clk, i_rst, issue, insn_valid, xfer_we;
  logic [31:0] word, insn, xfer_data, o_rd_data, got;
  logic [2:0]  fsel, xfer_sel, rd_sel;
  logic        o_transfer_valid, o_dsp_cond_flag, o_op_executed, o_op_illegal;
  logic [15:0] o_transfer_field;
  int          err_count, n_compared;
  case_s       cs [17];
  logic [31:0] init_v [8];
  //////////////////////////////////////////////////////////////////////////////
  core_issue_model core (.i_ref_clk(i_ref_clk), .i_issue(issue), .i_word(word),
    .o_insn_valid(insn_valid), .o_insn(insn));
  dsp_operation_decoder dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_insn_valid(insn_valid), .i_insn(insn), .i_flag_update_select(fsel),
    .i_xfer_we(xfer_we), .i_xfer_sel(xfer_sel), .i_xfer_data(xfer_data),
    .i_rd_sel(rd_sel), .o_rd_data(o_rd_data), .o_transfer_valid(o_transfer_valid),
    .o_transfer_field(o_transfer_field), .o_dsp_cond_flag(o_dsp_cond_flag),
    .o_op_executed(o_op_executed), .o_op_illegal(o_op_illegal));
  // 125 MHz reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compares %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t word got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t bit got %b want %b", $time, g, e);
    end
  endtask
  // drive just after the edge; request stays up through the next edge
  task automatic send(input logic [31:0] w);
    @(posedge i_ref_clk); #1;
    issue = 1'b1;
    word  = w;
  endtask
  task automatic idle();
    @(posedge i_ref_clk); #1;
    issue = 1'b0;
  endtask
  task automatic load(input logic [2:0] r, input logic [31:0] v);
    @(posedge i_ref_clk); #1;
    xfer_we = 1'b1; xfer_sel = r; xfer_data = v;
    @(posedge i_ref_clk); #1;
    xfer_we = 1'b0;
  endtask
  // read data shows the value sampled at the edge after the select
  task automatic rd(input logic [2:0] r, output logic [31:0] v);
    @(posedge i_ref_clk); #1;
    rd_sel = r;
    @(posedge i_ref_clk); #1;
    v = o_rd_data;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // hang guard: the full sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    err_count++;
    final_report();
  end
  initial begin
    init_v = '{32'h00000000, 32'h00050000, 32'h00000010, 32'hFFFFFFF0,
               32'h00030000, 32'h7FFFFFFF, 32'hFFFE0000, 32'h00020000};
    cs[0]  = '{1'b1, 16'hA190, 3'h1, 3'h0, 32'h00030010, 1'b0, 1'b1, 1'b0};
    cs[1]  = '{1'b1, 16'hB1C5, 3'h1, 3'h5, 32'h8000000F, 1'b1, 1'b1, 1'b0};
    cs[2]  = '{1'b1, 16'hB340, 3'h1, 3'h0, 32'h00030010, 1'b1, 1'b0, 1'b0};
    cs[3]  = '{1'b1, 16'hA262, 3'h1, 3'h2, 32'h00070000, 1'b1, 1'b1, 1'b0};
    cs[4]  = '{1'b1, 16'hB2A3, 3'h1, 3'h3, 32'h00010000, 1'b1, 1'b1, 1'b0};
    cs[5]  = '{1'b1, 16'hA381, 3'h1, 3'h1, 32'h00050000, 1'b1, 1'b0, 1'b0};
    cs[6]  = '{1'b1, 16'h91B0, 3'h1, 3'h0, 32'h000C0000, 1'b0, 1'b1, 1'b0};
    cs[7]  = '{1'b1, 16'h92F0, 3'h1, 3'h0, 32'h000C0000, 1'b0, 1'b0, 1'b0};
    cs[8]  = '{1'b1, 16'hB314, 3'h1, 3'h4, 32'h000D0000, 1'b0, 1'b1, 1'b0};
    cs[9]  = '{1'b1, 16'h91E2, 3'h1, 3'h2, 32'hE0000003, 1'b1, 1'b1, 1'b0};
    cs[10] = '{1'b1, 16'h764D, 3'h2, 3'h1, 32'hE0050003, 1'b0, 1'b1, 1'b0};
    cs[11] = '{1'b1, 16'h6118, 3'h0, 3'h0, 32'h000C001A, 1'b1, 1'b1, 1'b0};
    cs[12] = '{1'b1, 16'h4F00, 3'h2, 3'h0, 32'hFFFFFFFC, 1'b1, 1'b1, 1'b0};
    cs[13] = '{1'b1, 16'hB108, 3'h1, 3'h0, 32'hFFFFFFFC, 1'b1, 1'b0, 1'b1};
    cs[14] = '{1'b0, 16'hB1C5, 3'h1, 3'h5, 32'h8000000F, 1'b1, 1'b0, 1'b0};
    cs[15] = '{1'b1, 16'hB147, 3'h3, 3'h7, 32'hE0036044, 1'b0, 1'b1, 1'b0};
    cs[16] = '{1'b1, 16'hB147, 3'h6, 3'h7, 32'hE0036044, 1'b0, 1'b1, 1'b0};
    err_count = 0; n_compared = 0;
    i_rst = 1'b1; issue = 1'b0; word = 32'h00000000; fsel = 3'h1;
    xfer_we = 1'b0; xfer_sel = 3'h0; xfer_data = 32'h00000000; rd_sel = 3'h0;
    repeat (20) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    chk_bit(o_dsp_cond_flag, 1'b0);
    for (int r = 0; r < 8; r++) load(3'(r), init_v[r]);
    for (int r = 0; r < 8; r++) begin
      rd(3'(r), got);
      chk_word(got, init_v[r]);
    end
    // each case: issue one word, look at the pulses, read the destination
    for (int k = 0; k < 17; k++) begin
      fsel = cs[k].sel;
      send({(cs[k].dsp ? 6'h3E : 6'h00), 10'h155, cs[k].lo});
      idle();
      chk_bit(o_transfer_valid, cs[k].dsp);
      chk_word({16'h0000, o_transfer_field}, {(cs[k].dsp ? 6'h3E : 6'h00), 26'h1550000} >> 16);
      chk_bit(o_op_executed, cs[k].ex);
      chk_bit(o_op_illegal, cs[k].il);
      chk_bit(o_dsp_cond_flag, cs[k].fl);
      rd(cs[k].d, got);
      chk_word(got, cs[k].v);
    end
    rd(3'h3, got);
    chk_word(got, 32'hFFFFFFE6);
    rd(3'h2, got);
    chk_word(got, 32'hFFFE6041);
    // back-to-back adds, the second reads the first one's result
    fsel = 3'h1;
    send(32'hF955B1A4);
    send(32'hF955B1A4);
    idle();
    rd(3'h4, got);
    chk_word(got, 32'h00090000);
    chk_bit(o_dsp_cond_flag, 1'b0);
    final_report();
  end
endmodule // dsp_operation_decoder_bench
